// ### hw/adc_seq_pkg.sv
/*
 * Shared constants and types of the conversion sequencer: register
 * offsets, field positions, clock selects and timing counts.
 * Assumes a single 10 MHz system clock and an 8-bit register port.
 */
package adc_seq_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_CONV_CONTROL_0 = 3'h0;
    localparam logic [2:0] ADDR_CONV_CONTROL_1 = 3'h1;
    localparam logic [2:0] ADDR_CONV_CONTROL_2 = 3'h2;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h4;
    localparam logic [2:0] ADDR_PERIPH_IRQ_FLAGS_1 = 3'h5;
    localparam logic [2:0] ADDR_PERIPH_IRQ_ENABLES_1 = 3'h6;

    // Field positions
    localparam int EN_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    localparam int CKS_LSB = 4;
    localparam int FMT_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 0;

    // Clock select code of the internal RC clock (x11)
    localparam logic [1:0] CKS_RC_LOW = 2'h3;

    // Conversion timing in half conversion-clock periods
    localparam logic [4:0] HALF_FIRST_DECIDE = 5'h03;
    localparam logic [4:0] HALF_TOTAL = 5'h17;
    localparam logic [4:0] HALF_LAST = 5'h16;

    // Number of hardware trigger sources
    localparam logic [4:0] TRIG_COUNT = 5'h0F;

    // Start code of the successive approximation register
    localparam logic [9:0] SAR_START = 10'h200;
    localparam logic [3:0] SAR_MSB = 4'h9;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } div_state_t;

    typedef struct packed {
        logic [4:0] channel_select;
        logic go;
        logic en;
        logic fmt;
        logic [2:0] cks;
        logic [4:0] trig;
        logic [14:0] trig_prev;
        logic [15:0] res;
        logic flag;
        logic irq_en;
        logic busy;
        logic pd;
        logic [4:0] hcnt;
        logic [3:0] bitpos;
        logic [9:0] sar;
        logic [9:0] dmask;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        logic analog_on;
    } seq_state_t;

endpackage : adc_seq_pkg

// ### hw/conv_clock_div.sv
/*
 * Conversion clock divider: one-cycle pulse per half conversion-clock period.
 * Assumes rc_tick is a one-cycle pulse already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module conv_clock_div
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic rc_tick,
    output logic half_tick
);

    div_state_t st;
    div_state_t nxt_st;
    logic [2:0] shift;
    logic [5:0] limit;

    always_comb
    begin
        // Half period is div/2 system cycles: 000,001,010 map to 1,4,16 and 100,101,110 to 2,8,32
        shift = {sel[1:0], sel[2]};
        limit = 6'(6'h01 << shift) - 6'h01;
        nxt_st = st;
        nxt_st.tick = 1'b0;
        if (!run)
        begin
            nxt_st.cnt = 6'h00;
        end
        else if (sel[1:0] == CKS_RC_LOW)
        begin
            nxt_st.cnt = 6'h00;
            nxt_st.tick = rc_tick;
        end
        else if (st.cnt >= limit)
        begin
            nxt_st.cnt = 6'h00;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= nxt_st;
    end

    assign half_tick = st.tick;

endmodule : conv_clock_div

`default_nettype wire

// ### hw/adc_conversion_sequencer.sv
/*
 * Control logic of a 10-bit successive-approximation converter: registers,
 * start by software or trigger, bit sequencing, abort, sleep and result format.
 * Assumes a synchronous comparator input and synchronous trigger levels.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    output logic [7:0] rdata,
    input wire logic sleep,
    input wire logic [14:0] trig_src,
    input wire logic rc_tick,
    input wire logic cmp_in,
    output logic [4:0] channel,
    output logic [9:0] dac_code,
    output logic conv_busy,
    output logic analog_on,
    output logic irq_req,
    output logic wake_req
);

    seq_state_t st;
    seq_state_t nxt_st;
    logic half_tick;
    logic rc_sel;
    logic wr_c0;
    logic [14:0] trig_rise;
    logic trig_hit;
    logic start_req;
    logic may_run;
    logic kill_now;
    logic sleep_kill;
    logic soft_abort;
    logic done_now;
    logic [9:0] low_one;
    logic last_bit;
    logic [9:0] fill;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock

    conv_clock_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(st.busy),
        .sel(st.cks),
        .rc_tick(rc_tick),
        .half_tick(half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Partial result: bits not yet decided copy the lowest decided bit

    assign low_one = st.dmask & ~{st.dmask[8:0], 1'b0};
    assign last_bit = |(st.sar & low_one);

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_fill
            assign fill[gi] = st.dmask[gi] ? st.sar[gi] : last_bit;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Event decode

    assign rc_sel = (st.cks[1:0] == CKS_RC_LOW);
    assign wr_c0 = reg_req.wr && (reg_req.addr == ADDR_CONV_CONTROL_0);
    assign trig_rise = trig_src & ~st.trig_prev;
    assign trig_hit = (st.trig < TRIG_COUNT) && trig_rise[st.trig[3:0]];
    // Go only takes effect with the enable set in the same write
    assign start_req = (wr_c0 && reg_req.wdata[GO_BIT] && reg_req.wdata[EN_BIT])
        || (trig_hit && st.en);
    // Non-RC clock cannot run in sleep, so a start then is dropped
    assign may_run = !st.pd && !(sleep && !rc_sel);
    assign kill_now = st.busy && wr_c0 && !reg_req.wdata[EN_BIT];
    assign sleep_kill = st.busy && sleep && !rc_sel;
    assign soft_abort = st.busy && wr_c0 && !reg_req.wdata[GO_BIT] && !kill_now
        && !sleep_kill;
    assign done_now = st.busy && half_tick && (st.hcnt == HALF_LAST) && !kill_now
        && !sleep_kill && !soft_abort;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_st = st;
        nxt_st.trig_prev = trig_src;
        nxt_st.rdata = 8'h00;

        if (wr_c0)
        begin
            nxt_st.channel_select = reg_req.wdata[CHS_LSB +: 5];
            nxt_st.en = reg_req.wdata[EN_BIT];
        end
        if (reg_req.wr && reg_req.addr == ADDR_CONV_CONTROL_1)
        begin
            nxt_st.fmt = reg_req.wdata[FMT_BIT];
            nxt_st.cks = reg_req.wdata[CKS_LSB +: 3];
        end
        if (reg_req.wr && reg_req.addr == ADDR_CONV_CONTROL_2)
            nxt_st.trig = reg_req.wdata[4:0];
        if (reg_req.wr && reg_req.addr == ADDR_PERIPH_IRQ_FLAGS_1)
            nxt_st.flag = reg_req.wdata[FLAG_BIT];
        if (reg_req.wr && reg_req.addr == ADDR_PERIPH_IRQ_ENABLES_1)
            nxt_st.irq_en = reg_req.wdata[IRQ_EN_BIT];

        // Power-down after sleep lasts until the device is awake again
        if (st.pd && !sleep)
            nxt_st.pd = 1'b0;

        if (st.busy)
        begin
            if (kill_now || sleep_kill)
            begin
                nxt_st.busy = 1'b0;
                nxt_st.go = 1'b0;
                nxt_st.pd = sleep_kill ? 1'b1 : nxt_st.pd;
            end
            else if (soft_abort)
            begin
                nxt_st.busy = 1'b0;
                nxt_st.go = 1'b0;
                nxt_st.res = st.fmt ? {fill, 6'h00} : {6'h00, fill};
            end
            else if (half_tick)
            begin
                nxt_st.hcnt = st.hcnt + 5'h01;
                // One bit per conversion-clock period, MSB first
                if (st.hcnt >= HALF_FIRST_DECIDE && st.hcnt[0] && !st.dmask[0])
                begin
                    nxt_st.sar[st.bitpos] = cmp_in;
                    nxt_st.dmask[st.bitpos] = 1'b1;
                    if (st.bitpos != 4'h0)
                    begin
                        nxt_st.bitpos = st.bitpos - 4'h1;
                        nxt_st.sar[st.bitpos - 4'h1] = 1'b1;
                    end
                end
                if (done_now)
                begin
                    nxt_st.busy = 1'b0;
                    nxt_st.go = 1'b0;
                    nxt_st.res = st.fmt ? {st.sar, 6'h00} : {6'h00, st.sar};
                    nxt_st.pd = (sleep && !st.irq_en) ? 1'b1 : nxt_st.pd;
                end
            end
        end
        else if (start_req && may_run)
        begin
            nxt_st.busy = 1'b1;
            nxt_st.go = 1'b1;
            nxt_st.hcnt = 5'h00;
            nxt_st.bitpos = SAR_MSB;
            nxt_st.sar = SAR_START;
            nxt_st.dmask = 10'h000;
        end

        // Hardware set wins over a software clear in the same cycle
        if (done_now)
            nxt_st.flag = 1'b1;

        nxt_st.irq = nxt_st.flag && nxt_st.irq_en;
        nxt_st.wake = nxt_st.irq && sleep;
        nxt_st.analog_on = nxt_st.en && !nxt_st.pd;

        if (reg_req.rd)
        begin
            case (reg_req.addr)
                ADDR_CONV_CONTROL_0: nxt_st.rdata = {1'b0, st.channel_select, st.go, st.en};
                ADDR_CONV_CONTROL_1: nxt_st.rdata = {st.fmt, st.cks, 4'h0};
                ADDR_CONV_CONTROL_2: nxt_st.rdata = {3'h0, st.trig};
                ADDR_RESULT_HIGH: nxt_st.rdata = st.res[15:8];
                ADDR_RESULT_LOW: nxt_st.rdata = st.res[7:0];
                ADDR_PERIPH_IRQ_FLAGS_1: nxt_st.rdata = {7'h00, st.flag};
                ADDR_PERIPH_IRQ_ENABLES_1: nxt_st.rdata = {7'h00, st.irq_en};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= nxt_st;
    end

    assign rdata = st.rdata;
    assign channel = st.channel_select;
    assign dac_code = st.sar;
    assign conv_busy = st.busy;
    assign analog_on = st.analog_on;
    assign irq_req = st.irq;
    assign wake_req = st.wake;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_flag_on_done: assert property (@(posedge clk) disable iff (!rst_n)
        done_now |=> st.flag)
        else $error("done flag not set at conversion end");

    a_flag_stays_set: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && st.flag && !(reg_req.wr && reg_req.addr == ADDR_PERIPH_IRQ_FLAGS_1))
        |=> st.flag)
        else $error("done flag cleared without a software write");

    a_wake_in_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        (done_now && st.irq_en && sleep && $past(sleep) && !reg_req.wr) |=> wake_req)
        else $error("no wake after sleep completion with interrupt on");

    a_go_clears_done: assert property (@(posedge clk) disable iff (!rst_n)
        done_now |=> (!st.go && !st.busy && st.res == (st.fmt ? {$past(st.sar), 6'h00}
        : {6'h00, $past(st.sar)})))
        else $error("completion did not clear go or load result");

    a_abort_fills: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_abort && !st.fmt) |=> (!st.go && st.res[9:0] == $past(fill)))
        else $error("abort result not filled from last converted bit");

    a_sleep_abort: assert property (@(posedge clk) disable iff (!rst_n)
        (sleep_kill && !wr_c0) |=> (!st.busy && st.en && st.pd && !analog_on))
        else $error("sleep with non-RC clock did not abort and power down");

    a_sleep_done_off: assert property (@(posedge clk) disable iff (!rst_n)
        (done_now && sleep && !st.irq_en && !reg_req.wr) |=> (!analog_on && st.en && st.pd))
        else $error("sleep completion without interrupt kept converter on");

    a_trigger_starts: assert property (@(posedge clk) disable iff (!rst_n)
        (trig_hit && st.en && !st.busy && may_run && !reg_req.wr) |=> (st.go && st.busy))
        else $error("trigger edge did not start a conversion");

    a_conv_length: assert property (@(posedge clk) disable iff (!rst_n)
        done_now |-> (st.hcnt == HALF_LAST && st.dmask == 10'h3FF))
        else $error("conversion ended at the wrong half period count");

    a_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(st.busy)) |-> (st.sar == SAR_START && st.dmask == 10'h000))
        else $error("conversion did not start from the MSB trial");

endmodule : adc_conversion_sequencer

`default_nettype wire

// ### verif/tb_top.sv
/*
 * Self-checking bench of the conversion sequencer: register port tasks, a
 * comparator model, and expected results worked out from the analog value.
 * Assumes the design package is compiled first and asserts live in the design.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
    import adc_seq_pkg::*;

    logic clk;
    logic rst_n;
    logic sleep;
    logic rc_tick;
    reg_req_t req;
    logic [14:0] trig_src;
    logic [7:0] rdata;
    logic [4:0] channel;
    logic [9:0] dac_code;
    logic [9:0] ain;
    logic conv_busy;
    logic analog_on;
    logic irq_req;
    logic wake_req;
    logic cmp_in;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'hd945;
    int n;
    logic seen;
    logic [7:0] d;
    logic [15:0] prior;
    logic [15:0] kept;
    // Divider per clock select code; codes x11 use the RC clock
    int div_tab [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

    adc_conversion_sequencer dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .reg_req(req),
        .rdata(rdata),
        .sleep(sleep),
        .trig_src(trig_src),
        .rc_tick(rc_tick),
        .cmp_in(cmp_in),
        .channel(channel),
        .dac_code(dac_code),
        .conv_busy(conv_busy),
        .analog_on(analog_on),
        .irq_req(irq_req),
        .wake_req(wake_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Ideal comparator: follows the registered trial code, so no race at edges
    assign cmp_in = (ain >= dac_code);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Irregular RC pulses: the sequence must not rely on an even rate
    always @(posedge clk)
        rc_tick <= ($random(seed) % 3 == 0);

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic wait_idle(input int lim, output int cnt);
        cnt = 0;
        #1;
        while (conv_busy === 1'b1 && cnt < lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= lim) `CHK("busy timeout", 1'b0, 1'b1)
    endtask : wait_idle

    function automatic logic [15:0] fmt_res(input logic [9:0] v, input logic f);
        return f ? {v, 6'h00} : {6'h00, v};
    endfunction : fmt_res

    task automatic get_res(output logic [15:0] r);
        logic [7:0] h;
        logic [7:0] l;
        rd(ADDR_RESULT_HIGH, h);
        rd(ADDR_RESULT_LOW, l);
        r = {h, l};
    endtask : get_res

    task automatic start(input logic [2:0] cks, input logic f, input logic [4:0] ch);
        ain <= 10'($random(seed));
        wr(ADDR_CONV_CONTROL_1, {f, cks, 4'h0});
        wr(ADDR_CONV_CONTROL_0, {1'b0, ch, 2'b01});
        repeat (4) @(posedge clk);
        wr(ADDR_CONV_CONTROL_0, {1'b0, ch, 2'b11});
    endtask : start

    task automatic convert(input logic [2:0] cks, input logic f, input logic [4:0] ch);
        int cnt;
        int lo;
        logic [7:0] v;
        logic [15:0] r;
        start(cks, f, ch);
        `CHK("channel", ch, channel)
        wait_idle(2000, cnt);
        lo = 23 * div_tab[cks] / 2;
        if (cks[1:0] != 2'b11) `CHK("conv cycles", 1'b1, cnt >= lo && cnt <= lo + div_tab[cks] + 2)
        rd(ADDR_CONV_CONTROL_0, v);
        `CHK("ctrl0 after done", {1'b0, ch, 2'b01}, v)
        rd(ADDR_PERIPH_IRQ_FLAGS_1, v);
        `CHK("done flag", 8'h01, v)
        get_res(r);
        `CHK("result", fmt_res(ain, f), r)
    endtask : convert

    task automatic summarize;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial
    begin
        req = '0;
        sleep = 1'b0;
        trig_src = '0;
        ain = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), d);
            `CHK("reset value", 8'h00, d)
        end
        wr(3'h7, 8'hFF);
        rd(3'h7, d);
        `CHK("unmapped", 8'h00, d)
        // Every divider in both formats
        for (int c = 0; c < 8; c++)
            for (int f = 0; f < 2; f++)
                if (c[1:0] != 2'b11)
                begin
                    convert(3'(c), f[0], 5'(c * 3 + f));
                    wr(ADDR_PERIPH_IRQ_FLAGS_1, 8'h00);
                end
        // Abort part way: undecided bits copy the lowest decided one
        start(3'h0, 1'b0, 5'h02);
        repeat (8) @(posedge clk);
        wr(ADDR_CONV_CONTROL_0, {1'b0, 5'h02, 2'b01});
        wait_idle(50, n);
        get_res(prior);
        seen = 1'b0;
        for (int k = 1; k < 10; k++)
        begin
            logic [9:0] e;
            e = ain;
            for (int b = 0; b < 10 - k; b++)
                e[b] = ain[10 - k];
            if ({6'h00, e} === prior)
                seen = 1'b1;
        end
        `CHK("partial result", 1'b1, seen)
        rd(ADDR_CONV_CONTROL_0, d);
        `CHK("go after abort", 8'h09, d)
        // Sleep on a divided clock kills the conversion
        start(3'h0, 1'b0, 5'h04);
        repeat (5) @(posedge clk);
        sleep <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK("busy in sleep", 1'b0, conv_busy)
        `CHK("powered in sleep", 1'b0, analog_on)
        rd(ADDR_CONV_CONTROL_0, d);
        `CHK("enable in sleep", 1'b1, d[EN_BIT])
        get_res(kept);
        `CHK("result kept", prior, kept)
        // Power-down holds until wake, so wake and sleep again before an RC run
        @(posedge clk);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        sleep <= 1'b1;
        #1 `CHK("power after wake", 1'b1, analog_on)
        // RC clock runs on in sleep; with interrupt off it powers down after
        convert(3'h3, 1'b0, 5'h1F);
        `CHK("power down after sleep conv", 1'b0, analog_on)
        @(posedge clk);
        sleep <= 1'b0;
        wr(ADDR_PERIPH_IRQ_FLAGS_1, 8'h00);
        wr(ADDR_PERIPH_IRQ_ENABLES_1, 8'h01);
        sleep <= 1'b1;
        convert(3'h7, 1'b1, 5'h03);
        `CHK("irq", 1'b1, irq_req)
        `CHK("wake", 1'b1, wake_req)
        wr(ADDR_PERIPH_IRQ_FLAGS_1, 8'h00);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("irq cleared", 1'b0, irq_req)
        `CHK("wake cleared", 1'b0, wake_req)
        // Hardware triggers: every source, plus a code that selects nothing
        wr(ADDR_CONV_CONTROL_1, 8'h00);
        for (int t = 0; t < 16; t++)
        begin
            wr(ADDR_CONV_CONTROL_2, 8'(t));
            @(posedge clk);
            trig_src <= (t < 15) ? 15'(1 << t) : 15'h7FFF;
            seen = 1'b0;
            repeat (4)
            begin
                @(posedge clk);
                #1;
                if (conv_busy === 1'b1)
                    seen = 1'b1;
            end
            `CHK("trigger start", (t < 15), seen)
            wait_idle(100, n);
            wr(ADDR_PERIPH_IRQ_FLAGS_1, 8'h00);
            trig_src <= '0;
        end
        // Reset in mid conversion
        start(3'h0, 1'b1, 5'h05);
        repeat (5) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1 `CHK("busy after reset", 1'b0, conv_busy)
        `CHK("power after reset", 1'b0, analog_on)
        rd(ADDR_CONV_CONTROL_0, d);
        `CHK("ctrl0 after reset", 8'h00, d)
        get_res(prior);
        `CHK("result after reset", 16'h0000, prior)
        summarize();
    end

endmodule : tb_top

`default_nettype wire
